// file: design/asd_regs.sv
// Analog status and debug register bank
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
// Operation
// R1: status bit 9 shows side driver short
// R2: status bit 8 shows center driver short
// R3: status bit 4 shows synth lock
// R4: overall bias code in bits 15:14
// R5: first-stage bias code in bits 13:12
// R6: bits 11:9 set class-A current, pull-down
// R7: bit 8 resets one, selects class-AB
// R8: bit 7 grounds unpowered center output
// R9: bit 6 grounds unpowered headphone outputs
// R10: bit 5 doubles class-A VAG current
// R11: bit 4 disables VAG class-AB current
// R12: bit 3 routes ADC mux to headphone
// R13: bit 2 offers headphone common to mux
// R14: bit 0 test paths, bit 1 mic loop; bit 0 gates only the bit 3 and bit 2 paths, the mic loop follows bit 1 alone
// R15: software leaves debug word at reset
// R16: remove headphone load before mux test
// R17: status reserved bits read zero
module asd_regs (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic side_short_in,
  input wire logic center_short_in,
  input wire logic synth_lock_in,
  input wire logic hp_powered,
  input wire logic center_powered,
  output asd_pkg::asd_debug_t debug_ctl,
  output asd_pkg::asd_analog_t analog_ctl,
  output logic irq
);

  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic [1:0] pwr1_ff;
  logic [1:0] pwr2_ff;
  logic [2:0] evt_prev_ff;
  asd_pkg::asd_debug_t debug_ff;
  logic [2:0] irq_sts_ff;
  logic [2:0] irq_mask_ff;
  logic [15:0] rdata_ff;
  logic [15:0] status_word;
  logic [2:0] evt_rise;
  logic sts_rd;
  logic wr_debug;
  logic wr_mask;

  // Exact match of the bus address against one register offset
  function automatic logic asd_hit(logic [7:0] a, logic [7:0] off);
    return a == off;
  endfunction

  // Two-stage synchronisers for analog status inputs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
    end else begin
      sync1_ff <= {side_short_in, center_short_in, synth_lock_in};
      sync2_ff <= sync1_ff;
    end
  end

  // Synchronisers for power state inputs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pwr1_ff <= 2'h0;
      pwr2_ff <= 2'h0;
    end else begin
      pwr1_ff <= {hp_powered, center_powered};
      pwr2_ff <= pwr1_ff;
    end
  end

  // Live status word, reserved bits zero
  always_comb begin
    status_word = 16'h0000; // R17
    status_word[asd_pkg::POS_SIDE_SHORT] = sync2_ff[2]; // R1
    status_word[asd_pkg::POS_CENTER_SHORT] = sync2_ff[1]; // R2
    status_word[asd_pkg::POS_LOCK] = sync2_ff[0]; // R3
  end

  // Debug control register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      debug_ff <= asd_pkg::DEBUG_RESET; // R7 R8 R9
    end else if (wr_debug) begin
      debug_ff <= wdata; // R4 R5 R6 R10 R11 R12 R13 R14
    end
  end

  assign debug_ctl = debug_ff;

  // Analog controls derived from debug word
  always_comb begin
    analog_ctl.hp_class_ab = debug_ff.hp_class_select; // R7
    analog_ctl.hp_out_grounded = debug_ff.hp_ground_hold && !pwr2_ff[1]; // R9
    analog_ctl.center_out_grounded =
      debug_ff.center_ground_hold && !pwr2_ff[0]; // R8
    analog_ctl.vag_ab_enable = !debug_ff.vag_class_a_only; // R11
    analog_ctl.vag_double =
      debug_ff.vag_current_double && debug_ff.vag_class_a_only; // R10
    analog_ctl.adcmux_to_hp =
      debug_ff.analog_test_enable && debug_ff.test_adcmux_to_hp; // R12
    analog_ctl.hp_common_to_mux =
      debug_ff.analog_test_enable && debug_ff.test_hp_common_to_mux; // R13
    analog_ctl.mic_loop = debug_ff.test_mic_loop_path; // R14
  end

  // Rising edges of status flags become events
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      evt_prev_ff <= 3'h0;
    end else begin
      evt_prev_ff <= sync2_ff;
    end
  end

  assign evt_rise = sync2_ff & ~evt_prev_ff;

  // Decoded bus strobes
  assign sts_rd = rd && asd_hit(addr, asd_pkg::OFF_IRQ_STATUS);
  assign wr_debug = wr && asd_hit(addr, asd_pkg::OFF_DEBUG);
  assign wr_mask = wr && asd_hit(addr, asd_pkg::OFF_IRQ_MASK);

  // Sticky event bits, set wins over read clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_sts_ff <= 3'h0;
    end else if (sts_rd) begin
      irq_sts_ff <= evt_rise;
    end else begin
      irq_sts_ff <= irq_sts_ff | evt_rise;
    end
  end

  // Interrupt mask register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_mask_ff <= asd_pkg::IRQ_MASK_RESET;
    end else if (wr_mask) begin
      irq_mask_ff <= wdata[2:0];
    end
  end

  assign irq = |(irq_sts_ff & irq_mask_ff);

  // Read data, one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_ff <= 16'h0000;
    end else if (rd) begin
      unique case (addr)
        asd_pkg::OFF_STATUS: rdata_ff <= status_word;
        asd_pkg::OFF_DEBUG: rdata_ff <= debug_ff;
        asd_pkg::OFF_IRQ_STATUS: rdata_ff <= {13'h0, irq_sts_ff};
        asd_pkg::OFF_IRQ_MASK: rdata_ff <= {13'h0, irq_mask_ff};
        default: rdata_ff <= 16'h0000;
      endcase
    end else begin
      rdata_ff <= 16'h0000;
    end
  end

  assign rdata = rdata_ff;

  // Status reads, pins seen through two sync stages
  side_flag_a: assert property ( // R1
    @(posedge clk_sys) disable iff (rst)
    rd && addr == asd_pkg::OFF_STATUS
    |=> rdata[asd_pkg::POS_SIDE_SHORT] == $past(side_short_in, 3))
    else $error("side short flag wrong");

  center_flag_a: assert property ( // R2
    @(posedge clk_sys) disable iff (rst)
    rd && addr == asd_pkg::OFF_STATUS
    |=> rdata[asd_pkg::POS_CENTER_SHORT] == $past(center_short_in, 3))
    else $error("center short flag wrong");

  lock_flag_a: assert property ( // R3
    @(posedge clk_sys) disable iff (rst)
    rd && addr == asd_pkg::OFF_STATUS
    |=> rdata[asd_pkg::POS_LOCK] == $past(synth_lock_in, 3))
    else $error("lock flag wrong");

  reserved_zero_a: assert property ( // R17
    @(posedge clk_sys) disable iff (rst)
    rd && addr == asd_pkg::OFF_STATUS
    |=> (rdata & 16'hFCEF) == 16'h0000)
    else $error("reserved status bits set");

  status_ro_a: assert property ( // R17
    @(posedge clk_sys) disable iff (rst)
    wr && addr == asd_pkg::OFF_STATUS
    |=> $stable(debug_ctl) && $stable(irq_mask_ff))
    else $error("status write changed a register");

  // Debug word writes, reads and hold
  debug_write_a: assert property ( // R4
    @(posedge clk_sys) disable iff (rst)
    wr && addr == asd_pkg::OFF_DEBUG
    |=> debug_ctl == $past(wdata))
    else $error("debug word not written");

  overall_bias_a: assert property ( // R4
    @(posedge clk_sys) disable iff (rst)
    wr && addr == asd_pkg::OFF_DEBUG
    |=> debug_ctl.hp_overall_bias_sel == $past(wdata[15:14]))
    else $error("overall bias field misplaced");

  stage_bias_a: assert property ( // R5
    @(posedge clk_sys) disable iff (rst)
    wr && addr == asd_pkg::OFF_DEBUG
    |=> debug_ctl.hp_first_stage_bias_sel == $past(wdata[13:12]))
    else $error("first-stage bias field misplaced");

  pop_level_a: assert property ( // R6
    @(posedge clk_sys) disable iff (rst)
    wr && addr == asd_pkg::OFF_DEBUG
    |=> debug_ctl.hp_pop_suppress_level == $past(wdata[11:9]))
    else $error("class-A current field misplaced");

  test_bits_a: assert property ( // R14
    @(posedge clk_sys) disable iff (rst)
    wr && addr == asd_pkg::OFF_DEBUG
    |=> debug_ctl.analog_test_enable == $past(wdata[0])
    && debug_ctl.test_mic_loop_path == $past(wdata[1]))
    else $error("test enable bits misplaced");

  debug_hold_a: assert property ( // R4
    @(posedge clk_sys) disable iff (rst)
    !(wr && addr == asd_pkg::OFF_DEBUG)
    |=> $stable(debug_ctl))
    else $error("debug word changed without write");

  debug_read_a: assert property ( // R4
    @(posedge clk_sys) disable iff (rst)
    rd && addr == asd_pkg::OFF_DEBUG
    |=> rdata == $past(debug_ctl))
    else $error("debug word read wrong");

  class_sel_a: assert property ( // R7
    @(posedge clk_sys) disable iff (rst)
    analog_ctl.hp_class_ab == debug_ctl.hp_class_select)
    else $error("class select mismatch");

  // Analog controls against the debug word and power pins
  hp_ground_a: assert property ( // R9
    @(posedge clk_sys) disable iff (rst)
    analog_ctl.hp_out_grounded
    == (debug_ctl.hp_ground_hold && !$past(hp_powered, 2)))
    else $error("headphone ground hold wrong");

  center_ground_a: assert property ( // R8
    @(posedge clk_sys) disable iff (rst)
    analog_ctl.center_out_grounded
    == (debug_ctl.center_ground_hold && !$past(center_powered, 2)))
    else $error("center ground hold wrong");

  vag_ab_a: assert property ( // R11
    @(posedge clk_sys) disable iff (rst)
    debug_ctl.vag_class_a_only
    |-> !analog_ctl.vag_ab_enable)
    else $error("vag class-AB not disabled");

  vag_ab_on_a: assert property ( // R11
    @(posedge clk_sys) disable iff (rst)
    !debug_ctl.vag_class_a_only
    |-> analog_ctl.vag_ab_enable)
    else $error("vag class-AB wrongly off");

  vag_double_a: assert property ( // R10
    @(posedge clk_sys) disable iff (rst)
    analog_ctl.vag_double
    |-> debug_ctl.vag_current_double)
    else $error("vag double wrong");

  vag_mode_a: assert property ( // R10
    @(posedge clk_sys) disable iff (rst)
    debug_ctl.vag_current_double && debug_ctl.vag_class_a_only
    |-> analog_ctl.vag_double)
    else $error("vag double missing in class-A");

  mux_route_a: assert property ( // R12
    @(posedge clk_sys) disable iff (rst)
    analog_ctl.adcmux_to_hp
    |-> debug_ctl.test_adcmux_to_hp)
    else $error("mux to headphone wrong");

  mux_gate_a: assert property ( // R14
    @(posedge clk_sys) disable iff (rst)
    analog_ctl.adcmux_to_hp
    |-> debug_ctl.analog_test_enable)
    else $error("mux path open outside test mode");

  common_mux_a: assert property ( // R13
    @(posedge clk_sys) disable iff (rst)
    analog_ctl.hp_common_to_mux
    |-> debug_ctl.test_hp_common_to_mux)
    else $error("common to mux wrong");

  common_gate_a: assert property ( // R14
    @(posedge clk_sys) disable iff (rst)
    analog_ctl.hp_common_to_mux
    |-> debug_ctl.analog_test_enable)
    else $error("common path open outside test mode");

  mic_loop_a: assert property ( // R14
    @(posedge clk_sys) disable iff (rst)
    analog_ctl.mic_loop == debug_ctl.test_mic_loop_path)
    else $error("mic loop wrong");

  // Interrupt status and mask
  mask_write_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    wr && addr == asd_pkg::OFF_IRQ_MASK
    |=> irq_mask_ff == $past(wdata[2:0]))
    else $error("mask not written");

  mask_read_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    rd && addr == asd_pkg::OFF_IRQ_MASK
    |=> rdata == {13'h0, $past(irq_mask_ff)})
    else $error("mask read wrong");

  sts_read_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    rd && addr == asd_pkg::OFF_IRQ_STATUS
    |=> rdata == {13'h0, $past(irq_sts_ff)})
    else $error("event status read wrong");

  sts_clear_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    sts_rd
    |=> irq_sts_ff == $past(evt_rise))
    else $error("event status not cleared");

  evt_set_a: assert property ( // R1 R2 R3
    @(posedge clk_sys) disable iff (rst)
    evt_rise != 3'h0
    |=> (irq_sts_ff & $past(evt_rise)) == $past(evt_rise))
    else $error("event lost");

  sts_hold_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    !sts_rd
    |=> (irq_sts_ff & $past(irq_sts_ff)) == $past(irq_sts_ff))
    else $error("event status dropped");

  side_event_a: assert property ( // R1
    @(posedge clk_sys) disable iff (rst)
    $past(side_short_in, 2) && !$past(side_short_in, 3)
    |=> irq_sts_ff[2])
    else $error("side short event missing");

  center_event_a: assert property ( // R2
    @(posedge clk_sys) disable iff (rst)
    $past(center_short_in, 2) && !$past(center_short_in, 3)
    |=> irq_sts_ff[1])
    else $error("center short event missing");

  lock_event_a: assert property ( // R3
    @(posedge clk_sys) disable iff (rst)
    $past(synth_lock_in, 2) && !$past(synth_lock_in, 3)
    |=> irq_sts_ff[0])
    else $error("lock event missing");

  irq_masked_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    irq_mask_ff == 3'h0
    |-> !irq)
    else $error("interrupt raised while masked");

  // Read data timing on the register bus
  rdata_idle_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    !rd
    |=> rdata == 16'h0000)
    else $error("read data outside read slot");

  unmapped_rd_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    rd && addr != asd_pkg::OFF_STATUS && addr != asd_pkg::OFF_DEBUG
    && addr != asd_pkg::OFF_IRQ_STATUS && addr != asd_pkg::OFF_IRQ_MASK
    |=> rdata == 16'h0000)
    else $error("unmapped read not zero");

endmodule // asd_regs

// file: pkg/asd_pkg.sv
// Package for the analog status and debug register bank
package asd_pkg;
  // Register offsets
  localparam logic [7:0] OFF_STATUS = 8'h36;
  localparam logic [7:0] OFF_DEBUG = 8'h38;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h40;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h42;
  // Status field positions
  localparam int POS_SIDE_SHORT = 9;
  localparam int POS_CENTER_SHORT = 8;
  localparam int POS_LOCK = 4;
  // Reset values
  localparam logic [15:0] DEBUG_RESET = 16'h01C0;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  // Number of interrupt events
  localparam int NUM_EVT = 3;

  // Bias encodings for the overall bias field
  typedef enum logic [1:0] {
    ALL_NOMINAL, ALL_MINUS_50, ALL_PLUS_50, ALL_MINUS_40
  } asd_all_bias_t;
  // Bias encodings for the first-stage bias field
  typedef enum logic [1:0] {
    ST1_NOMINAL, ST1_MINUS_50, ST1_PLUS_100, ST1_PLUS_50
  } asd_st1_bias_t;

  // Debug control word layout
  typedef struct packed {
    asd_all_bias_t hp_overall_bias_sel;
    asd_st1_bias_t hp_first_stage_bias_sel;
    logic [2:0] hp_pop_suppress_level;
    logic hp_class_select;
    logic center_ground_hold;
    logic hp_ground_hold;
    logic vag_current_double;
    logic vag_class_a_only;
    logic test_adcmux_to_hp;
    logic test_hp_common_to_mux;
    logic test_mic_loop_path;
    logic analog_test_enable;
  } asd_debug_t;

  // Analog controls derived for the analog side
  typedef struct packed {
    logic hp_class_ab;
    logic hp_out_grounded;
    logic center_out_grounded;
    logic vag_ab_enable;
    logic vag_double;
    logic adcmux_to_hp;
    logic hp_common_to_mux;
    logic mic_loop;
  } asd_analog_t;
endpackage

// file: bench/tb_asd_regs.sv
// Self-checking bench for the analog status and debug bank
`timescale 1ns/1ps
module tb_asd_regs;
  logic clk_sys, rst, wr, rd, irq;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, v, st, dbg;
  logic side_short_in, center_short_in, synth_lock_in;
  logic hp_powered, center_powered;
  asd_pkg::asd_debug_t debug_ctl;
  asd_pkg::asd_analog_t analog_ctl;
  int err_total, n_checks, seed;
  logic [2:0] ev, ev_old, ist, msk;
  logic [7:0] ana;

  asd_regs i_dut (
    .clk_sys(clk_sys),
    .rst(rst),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .side_short_in(side_short_in),
    .center_short_in(center_short_in),
    .synth_lock_in(synth_lock_in),
    .hp_powered(hp_powered),
    .center_powered(center_powered),
    .debug_ctl(debug_ctl),
    .analog_ctl(analog_ctl),
    .irq(irq)
  );

  // 50 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Compare seen value with expected one
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle register write
  task automatic reg_wr(logic [7:0] a, logic [15:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  // One-cycle register read, data taken in the following cycle
  task automatic reg_rd(logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Verdict and end of run
  task automatic finish_test();
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    seed = 32'h3865B274;
    err_total = 0;
    n_checks = 0;
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    {side_short_in, center_short_in, synth_lock_in} = 3'h0;
    hp_powered = 1'b0;
    center_powered = 1'b0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    reg_rd(asd_pkg::OFF_DEBUG, v);
    check("debug_reset", v, 16'h01C0);
    check("analog_reset", {8'h00, analog_ctl}, 16'h00F0);
    check("irq_reset", {15'h0000, irq}, 16'h0000);
    ev_old = 3'h0;
    ist = 3'h0;
    for (int i = 0; i < 40; i++) begin
      ev = 3'($random(seed));
      msk = 3'($random(seed));
      dbg = 16'($random(seed));
      reg_wr(asd_pkg::OFF_IRQ_MASK, {13'h0000, msk});
      // No headphone load is modelled, so the mux path may be opened
      reg_wr(asd_pkg::OFF_DEBUG, dbg);
      reg_wr(8'h50, ~dbg);
      @(posedge clk_sys);
      {side_short_in, center_short_in, synth_lock_in} <= ev;
      hp_powered <= 1'($random(seed));
      center_powered <= 1'($random(seed));
      repeat (4) @(posedge clk_sys);
      ist = ist | (ev & ~ev_old);
      ev_old = ev;
      #1 check("irq", {15'h0000, irq}, {15'h0000, |(ist & msk)});
      st = {6'h00, ev[2], ev[1], 3'h0, ev[0], 4'h0};
      reg_rd(asd_pkg::OFF_STATUS, v);
      check("status", v, st);
      reg_rd(asd_pkg::OFF_IRQ_STATUS, v);
      check("irq_status", v, {13'h0000, ist});
      ist = 3'h0;
      #1 check("irq_clear", {15'h0000, irq}, 16'h0000);
      reg_wr(asd_pkg::OFF_STATUS, ~st);
      reg_rd(asd_pkg::OFF_STATUS, v);
      check("status_ro", v, st);
      reg_rd(8'h50, v);
      check("unmapped", v, 16'h0000);
      reg_rd(asd_pkg::OFF_DEBUG, v);
      check("debug", v, dbg);
      check("debug_ctl", debug_ctl, dbg);
      ana = {dbg[8], dbg[6] & ~hp_powered, dbg[7] & ~center_powered,
             ~dbg[4], dbg[5] & dbg[4], dbg[3] & dbg[0],
             dbg[2] & dbg[0], dbg[1]};
      check("analog", {8'h00, analog_ctl}, {8'h00, ana});
    end
    // Normal operation returns the debug word to its reset value
    reg_wr(asd_pkg::OFF_DEBUG, asd_pkg::DEBUG_RESET);
    reg_rd(asd_pkg::OFF_DEBUG, v);
    check("debug_restore", v, 16'h01C0);
    finish_test();
  end
endmodule // tb_asd_regs
